// ### hw/sfs_pkg.sv
package sfs_pkg;

    // Time base
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

    // Register byte offsets
    localparam logic [7:0] OFS_C2_SEL = 8'h00;
    localparam logic [7:0] OFS_C3_SEL = 8'h04;
    localparam logic [7:0] OFS_OT_SEL = 8'h08;
    localparam logic [7:0] OFS_FAST   = 8'h0c;
    localparam logic [7:0] OFS_SLOW   = 8'h10;
    localparam logic [7:0] OFS_BRAKE  = 8'h14;
    localparam logic [7:0] OFS_OCTHR  = 8'h18;
    localparam logic [7:0] OFS_MASK   = 8'h1c;
    localparam logic [7:0] OFS_RATED  = 8'h20;
    localparam logic [7:0] OFS_PHTOL  = 8'h24;
    localparam logic [7:0] OFS_CTRL   = 8'h28;
    localparam logic [7:0] OFS_STAT   = 8'h2c;

    // Values after reset
    localparam logic [15:0] RST_SEL   = 16'h0000;
    localparam logic [15:0] RST_FAST  = 16'h01f4;
    localparam logic [15:0] RST_SLOW  = 16'h03e8;
    localparam logic [15:0] RST_BRAKE = 16'h0000;
    localparam logic [15:0] RST_OCTHR = 16'h012c;
    localparam logic [15:0] RST_MASK  = 16'h0000;
    localparam logic [15:0] RST_RATED = 16'h00dc;
    localparam logic [15:0] RST_PHTOL = 16'h0010;
    localparam logic [3:0]  RST_SYNC  = 4'h2;

    // Stop modes
    localparam logic [2:0] MODE_COAST     = 3'h0;
    localparam logic [2:0] MODE_FAST_OFF  = 3'h1;
    localparam logic [2:0] MODE_SLOW_OFF  = 3'h2;
    localparam logic [2:0] MODE_FAST_HOLD = 3'h3;
    localparam logic [2:0] MODE_SLOW_HOLD = 3'h4;
    localparam logic [2:0] MODE_BRAKE     = 3'h5;
    localparam logic [15:0] MODE_MAX      = 16'h0005;

    // Thresholds
    localparam logic [15:0] OV_220    = 16'h01a4;
    localparam logic [15:0] OV_380    = 16'h02ee;
    localparam logic [15:0] UV_NUM    = 16'h26aa;
    localparam logic [15:0] UV_DEN    = 16'h2710;
    localparam logic [15:0] JUMP_PCT  = 16'h0032;
    localparam int          MASK_OC_BIT = 1;

    // Fault bits and their codes
    localparam int F_OC = 0;
    localparam int F_OV = 1;
    localparam int F_UV = 2;
    localparam int F_CS = 3;
    localparam int F_ENC = 4;
    localparam int F_NVM = 5;
    localparam int F_PH = 6;
    localparam int F_IPC = 7;
    localparam int F_JMP = 8;
    localparam int F_NOIDX = 9;
    localparam int F_NOOFS = 10;
    localparam int NUM_F = 11;
    localparam logic [9:0] FCODE [NUM_F] = '{10'h064, 10'h066, 10'h067, 10'h068, 10'h069,
                                              10'h06a, 10'h06b, 10'h06c, 10'h06d, 10'h071, 10'h072};
    localparam logic [9:0] C1_LO = 10'h064;
    localparam logic [9:0] C1_HI = 10'h0c7;
    localparam logic [9:0] C2_HI = 10'h257;
    localparam logic [9:0] OT_SW_CODE = 10'h0cf;
    localparam logic [9:0] OT_HW_CODE = 10'h0d0;

    // Pin synchroniser bit positions
    localparam int S_RELAY = 0;
    localparam int S_ENC   = 1;
    localparam int S_V380  = 2;
    localparam int S_OT    = 3;

    typedef struct packed {
        logic        valid;
        logic [15:0] pct;
    } sfs_sample_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] wr;
        logic [15:0] rd;
    } sfs_check_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] hall;
        logic [15:0] enc;
    } sfs_phase_t;

    typedef enum logic [2:0] {ST_RUN, ST_COAST, ST_DECEL, ST_HOLD, ST_OFF, ST_BRAKE} sfs_state_t;

endpackage

// ### hw/sfs_top.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Class III stop selector takes 0..5, acts at once, resets to 0.
// - Over-travel stop selector, same encoding, acts at once, resets to 0.
// - Mode 0 drops drive enable at once; motor coasts.
// - Modes 3/4 ramp fast/slow, then stay enabled at standstill.
// - Mode 5 brakes with the braking current setting.
// - Fast stop time in ms, 0..65535, resets to 500.
// - Slow stop time in ms, 0..65535, resets to 1000.
// - Code 100 when current percent exceeds the overcurrent threshold.
// - Mask word bit 1 suppresses code 100.
// - 220 V variant: code 102 above 420 V bus.
// - 380 V variant: code 102 above 750 V bus.
// - Code 103 when bus below rated times 1.414 times 0.7 after relay first closes.
// - Code 104 if current nonzero before relay first closes.
// - Code 105 when encoder missing or failed.
// - Code 106 on memory readback mismatch.
// - Code 108 on inter-processor readback mismatch.
// - Code 109 when successive current samples differ by 50 percent.
// - Code 107 when Hall and encoder phase disagree too much.
// - Self-learning: code 113 no index, code 114 no index offset.
// - Codes 100..199 cut power at once, ignoring any selector.
// - Class II faults use their own 0..5 selector, reset 0.
// - Ramp time is set time times fault speed over rated speed.
// - Modes 1/2 ramp fast/slow energised, then disable at standstill.
module sfs_top
    import sfs_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        relay_closed_pin,
    input  wire logic        encoder_present_pin,
    input  wire logic        variant_380_pin,
    input  wire logic        hw_overtravel_pin,
    input  wire logic        sw_overtravel,
    input  wire sfs_sample_t measured_current_percent,
    input  wire logic [15:0] bus_voltage_reading,
    input  wire sfs_check_t  nvm_check,
    input  wire sfs_check_t  ipc_check,
    input  wire sfs_phase_t  phase_check,
    input  wire logic        learn_no_index,
    input  wire logic        learn_no_offset,
    input  wire logic        ext_fault_valid,
    input  wire logic [9:0]  ext_fault_code,
    input  wire logic [15:0] motor_speed,
    input  wire logic [15:0] rated_speed,
    output logic             drive_enable,
    output logic             decel_active,
    output logic [15:0]      brake_current,
    output logic [9:0]       fault_code,
    output logic             fault_pending
);

    function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; encoder-present pin starts high so reset does not fake code 105
    logic [3:0] sync1_q, sync2_q;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sync1_q <= RST_SYNC;
            sync2_q <= RST_SYNC;
        end else begin
            sync1_q <= {hw_overtravel_pin, variant_380_pin, encoder_present_pin, relay_closed_pin};
            sync2_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB register file, zero wait states
    logic [15:0] c2_sel_q, c3_sel_q, ot_sel_q, fast_q, slow_q, brake_q, octhr_q, mask_q, rated_q, phtol_q;
    logic [15:0] c2_sel_d, c3_sel_d, ot_sel_d, fast_d, slow_d, brake_d, octhr_d, mask_d, rated_d, phtol_d;
    logic        wr_en, clr;
    logic        mapped;

    assign wr_en   = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign mapped  = (paddr <= OFS_STAT) && (paddr[1:0] == 2'b00);
    assign pslverr = psel && penable && !mapped;
    assign clr     = wr_en && (paddr == OFS_CTRL) && pwdata[0];

    always_comb begin
        c2_sel_d = c2_sel_q;
        c3_sel_d = c3_sel_q;
        ot_sel_d = ot_sel_q;
        fast_d   = fast_q;
        slow_d   = slow_q;
        brake_d  = brake_q;
        octhr_d  = octhr_q;
        mask_d   = mask_q;
        rated_d  = rated_q;
        phtol_d  = phtol_q;
        if (wr_en) begin
            // Out-of-range stop modes are ignored rather than clipped
            case (paddr)
                OFS_C2_SEL: if (pwdata[15:0] <= MODE_MAX) c2_sel_d = pwdata[15:0];
                OFS_C3_SEL: if (pwdata[15:0] <= MODE_MAX) c3_sel_d = pwdata[15:0];
                OFS_OT_SEL: if (pwdata[15:0] <= MODE_MAX) ot_sel_d = pwdata[15:0];
                OFS_FAST:   fast_d  = pwdata[15:0];
                OFS_SLOW:   slow_d  = pwdata[15:0];
                OFS_BRAKE:  brake_d = pwdata[15:0];
                OFS_OCTHR:  octhr_d = pwdata[15:0];
                OFS_MASK:   mask_d  = pwdata[15:0];
                OFS_RATED:  rated_d = pwdata[15:0];
                OFS_PHTOL:  phtol_d = pwdata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            c2_sel_q <= RST_SEL;
            c3_sel_q <= RST_SEL;
            ot_sel_q <= RST_SEL;
            fast_q   <= RST_FAST;
            slow_q   <= RST_SLOW;
            brake_q  <= RST_BRAKE;
            octhr_q  <= RST_OCTHR;
            mask_q   <= RST_MASK;
            rated_q  <= RST_RATED;
            phtol_q  <= RST_PHTOL;
        end else begin
            c2_sel_q <= c2_sel_d;
            c3_sel_q <= c3_sel_d;
            ot_sel_q <= ot_sel_d;
            fast_q   <= fast_d;
            slow_q   <= slow_d;
            brake_q  <= brake_d;
            octhr_q  <= octhr_d;
            mask_q   <= mask_d;
            rated_q  <= rated_d;
            phtol_q  <= phtol_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Fault detection and latching
    logic [NUM_F-1:0] flt_q, flt_d, det;
    logic [15:0]      prev_pct_q, prev_pct_d, ov_lim;
    logic             prev_ok_q, prev_ok_d, pwrup_q, pwrup_d;
    logic             c1x_q, c1x_d, c2_q, c2_d, c3_q, c3_d, ot_q, ot_d;
    logic [9:0]       c1x_code_q, c1x_code_d, c2_code_q, c2_code_d, c3_code_q, c3_code_d, ot_code_q, ot_code_d;
    logic             ot_event;

    assign ov_lim   = sync2_q[S_V380] ? OV_380 : OV_220;
    assign ot_event = sw_overtravel || sync2_q[S_OT];

    always_comb begin
        det = '0;
        det[F_OC]    = measured_current_percent.valid && (measured_current_percent.pct > octhr_q)
                       && !mask_q[MASK_OC_BIT];
        det[F_OV]    = bus_voltage_reading > ov_lim;
        // Undervoltage waits for the relay, else every power-up would trip
        det[F_UV]    = !pwrup_q && ({16'h0000, bus_voltage_reading} * {16'h0000, UV_DEN}
                       < {16'h0000, rated_q} * {16'h0000, UV_NUM});
        det[F_CS]    = pwrup_q && measured_current_percent.valid
                       && (measured_current_percent.pct != 16'h0000);
        det[F_ENC]   = !sync2_q[S_ENC];
        det[F_NVM]   = nvm_check.valid && (nvm_check.wr != nvm_check.rd);
        det[F_PH]    = phase_check.valid && (absdiff(phase_check.hall, phase_check.enc) > phtol_q);
        det[F_IPC]   = ipc_check.valid && (ipc_check.wr != ipc_check.rd);
        det[F_JMP]   = measured_current_percent.valid && prev_ok_q
                       && (absdiff(measured_current_percent.pct, prev_pct_q) >= JUMP_PCT);
        det[F_NOIDX] = learn_no_index;
        det[F_NOOFS] = learn_no_offset;
        // New events win over a clear in the same cycle
        flt_d      = (clr ? '0 : flt_q) | det;
        prev_pct_d = measured_current_percent.valid ? measured_current_percent.pct : prev_pct_q;
        prev_ok_d  = prev_ok_q || measured_current_percent.valid;
        pwrup_d    = pwrup_q && !sync2_q[S_RELAY];
        c1x_d      = c1x_q && !clr;
        c2_d       = c2_q && !clr;
        c3_d       = c3_q && !clr;
        ot_d       = (ot_q && !clr) || ot_event;
        c1x_code_d = c1x_d ? c1x_code_q : 10'h000;
        c2_code_d  = c2_d ? c2_code_q : 10'h000;
        c3_code_d  = c3_d ? c3_code_q : 10'h000;
        ot_code_d  = ot_d ? ot_code_q : 10'h000;
        if (ot_event && !(ot_q && !clr))
            ot_code_d = sw_overtravel ? OT_SW_CODE : OT_HW_CODE;
        if (ext_fault_valid) begin
            // First code of each class is kept for reporting
            if (ext_fault_code >= C1_LO && ext_fault_code <= C1_HI) begin
                if (!c1x_d) c1x_code_d = ext_fault_code;
                c1x_d = 1'b1;
            end else if (ext_fault_code > C1_HI && ext_fault_code <= C2_HI) begin
                if (!c2_d) c2_code_d = ext_fault_code;
                c2_d = 1'b1;
            end else if (ext_fault_code > C2_HI) begin
                if (!c3_d) c3_code_d = ext_fault_code;
                c3_d = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            flt_q      <= '0;
            prev_pct_q <= 16'h0000;
            prev_ok_q  <= 1'b0;
            pwrup_q    <= 1'b1;
            c1x_q      <= 1'b0;
            c2_q       <= 1'b0;
            c3_q       <= 1'b0;
            ot_q       <= 1'b0;
            c1x_code_q <= 10'h000;
            c2_code_q  <= 10'h000;
            c3_code_q  <= 10'h000;
            ot_code_q  <= 10'h000;
        end else begin
            flt_q      <= flt_d;
            prev_pct_q <= prev_pct_d;
            prev_ok_q  <= prev_ok_d;
            pwrup_q    <= pwrup_d;
            c1x_q      <= c1x_d;
            c2_q       <= c2_d;
            c3_q       <= c3_d;
            ot_q       <= ot_d;
            c1x_code_q <= c1x_code_d;
            c2_code_q  <= c2_code_d;
            c3_code_q  <= c3_code_d;
            ot_code_q  <= ot_code_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Stop mode selection by severity
    logic       c1, any_flt;
    logic [2:0] mode;
    logic [9:0] rep_code;

    assign c1      = (|flt_q) || c1x_q;
    assign any_flt = c1 || ot_q || c2_q || c3_q;

    always_comb begin
        rep_code = 10'h000;
        if (c1) begin
            rep_code = c1x_code_q;
            for (int i = NUM_F - 1; i >= 0; i--) begin
                if (flt_q[i]) rep_code = FCODE[i];
            end
        end else if (ot_q) rep_code = ot_code_q;
        else if (c2_q) rep_code = c2_code_q;
        else if (c3_q) rep_code = c3_code_q;
        // Selectors are read live, so a write acts on the very next decision
        if (c1) mode = MODE_COAST;
        else if (ot_q) mode = ot_sel_q[2:0];
        else if (c2_q) mode = c2_sel_q[2:0];
        else mode = c3_sel_q[2:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Stop sequencer; ramp length is fixed when the ramp starts
    sfs_state_t  st_q, st_d;
    logic [31:0] ramp_q, ramp_d, tick_q, tick_d, ramp_calc, prod;
    logic [15:0] set_ms, brake_cur_q, brake_cur_d;
    logic        drive_en_q, drive_en_d;
    logic [9:0]  code_q;
    logic        ms_tick;

    assign ms_tick = (tick_q == 32'(MS_CYC - 1));
    assign set_ms  = (mode == MODE_FAST_OFF || mode == MODE_FAST_HOLD) ? fast_q : slow_q;
    assign prod    = {16'h0000, set_ms} * {16'h0000, motor_speed};
    assign ramp_calc = (rated_speed == 16'h0000) ? {16'h0000, set_ms}
                       : prod / {16'h0000, rated_speed};

    always_comb begin
        st_d   = st_q;
        ramp_d = ramp_q;
        tick_d = ms_tick ? 32'h0000_0000 : tick_q + 32'h0000_0001;
        case (st_q)
            ST_RUN: begin
                if (any_flt) begin
                    case (mode)
                        MODE_COAST: st_d = ST_COAST;
                        MODE_BRAKE: st_d = ST_BRAKE;
                        default: begin
                            st_d   = ST_DECEL;
                            ramp_d = ramp_calc;
                            tick_d = 32'h0000_0000;
                        end
                    endcase
                end
            end
            ST_DECEL: begin
                if (c1 || mode == MODE_COAST) st_d = ST_COAST;
                else if (ramp_q == 32'h0000_0000) begin
                    if (mode == MODE_FAST_OFF || mode == MODE_SLOW_OFF) st_d = ST_OFF;
                    else if (mode == MODE_BRAKE) st_d = ST_BRAKE;
                    else st_d = ST_HOLD;
                end else if (ms_tick) ramp_d = ramp_q - 32'h0000_0001;
            end
            ST_HOLD, ST_OFF, ST_BRAKE: begin
                if (c1 || mode == MODE_COAST) st_d = ST_COAST;
                else if (!any_flt) st_d = ST_RUN;
            end
            ST_COAST: if (!any_flt) st_d = ST_RUN;
            default: st_d = ST_COAST;
        endcase
        drive_en_d  = !(st_d == ST_COAST || st_d == ST_OFF);
        brake_cur_d = (st_d == ST_BRAKE) ? brake_q : 16'h0000;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_q        <= ST_RUN;
            ramp_q      <= 32'h0000_0000;
            tick_q      <= 32'h0000_0000;
            drive_en_q  <= 1'b1;
            brake_cur_q <= 16'h0000;
            code_q      <= 10'h000;
        end else begin
            st_q        <= st_d;
            ramp_q      <= ramp_d;
            tick_q      <= tick_d;
            drive_en_q  <= drive_en_d;
            brake_cur_q <= brake_cur_d;
            code_q      <= rep_code;
        end
    end

    assign drive_enable  = drive_en_q;
    assign decel_active  = (st_q == ST_DECEL);
    assign brake_current = brake_cur_q;
    assign fault_code    = code_q;
    assign fault_pending = any_flt;

    always_comb begin
        case (paddr)
            OFS_C2_SEL: prdata = {16'h0000, c2_sel_q};
            OFS_C3_SEL: prdata = {16'h0000, c3_sel_q};
            OFS_OT_SEL: prdata = {16'h0000, ot_sel_q};
            OFS_FAST:   prdata = {16'h0000, fast_q};
            OFS_SLOW:   prdata = {16'h0000, slow_q};
            OFS_BRAKE:  prdata = {16'h0000, brake_q};
            OFS_OCTHR:  prdata = {16'h0000, octhr_q};
            OFS_MASK:   prdata = {16'h0000, mask_q};
            OFS_RATED:  prdata = {16'h0000, rated_q};
            OFS_PHTOL:  prdata = {16'h0000, phtol_q};
            OFS_STAT:   prdata = {6'h00, flt_q, drive_en_q, any_flt, st_q, code_q};
            default:    prdata = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    property p_c3_range;
        (wr_en && paddr == OFS_C3_SEL && pwdata[15:0] > MODE_MAX) |=> $stable(c3_sel_q);
    endproperty
    a_c3_range: assert property (p_c3_range) else $error("class3 selector took out-of-range mode");

    property p_ot_write;
        (wr_en && paddr == OFS_OT_SEL && pwdata[15:0] <= MODE_MAX) |=> ot_sel_q == $past(pwdata[15:0]);
    endproperty
    a_ot_write: assert property (p_ot_write) else $error("overtravel selector not written");

    property p_fast_rst;
        $fell(srst) |-> (fast_q == RST_FAST);
    endproperty
    a_fast_rst: assert property (p_fast_rst) else $error("fast stop time reset value wrong");

    property p_slow_rst;
        $fell(srst) |-> (slow_q == RST_SLOW);
    endproperty
    a_slow_rst: assert property (p_slow_rst) else $error("slow stop time reset value wrong");

    property p_oc;
        (measured_current_percent.valid && measured_current_percent.pct > octhr_q && !mask_q[MASK_OC_BIT])
            |=> flt_q[F_OC];
    endproperty
    a_oc: assert property (p_oc) else $error("overcurrent not latched");

    property p_oc_mask;
        (mask_q[MASK_OC_BIT] && !flt_q[F_OC]) |=> !flt_q[F_OC];
    endproperty
    a_oc_mask: assert property (p_oc_mask) else $error("masked overcurrent was raised");

    property p_ov220;
        (!sync2_q[S_V380] && bus_voltage_reading > OV_220) |=> flt_q[F_OV];
    endproperty
    a_ov220: assert property (p_ov220) else $error("overvoltage not latched");

    property p_jump;
        (measured_current_percent.valid && prev_ok_q
            && absdiff(measured_current_percent.pct, prev_pct_q) >= JUMP_PCT) |=> flt_q[F_JMP];
    endproperty
    a_jump: assert property (p_jump) else $error("current jump not latched");

    property p_coast;
        (st_q == ST_RUN && c1) |=> (st_q == ST_COAST && !drive_enable);
    endproperty
    a_coast: assert property (p_coast) else $error("class1 fault did not coast");

    property p_hold;
        (st_q == ST_DECEL && ramp_q == 32'h0000_0000 && !c1
            && (mode == MODE_FAST_HOLD || mode == MODE_SLOW_HOLD)) |=> (st_q == ST_HOLD && drive_enable);
    endproperty
    a_hold: assert property (p_hold) else $error("hold mode did not stay enabled");

    property p_off;
        (st_q == ST_DECEL && ramp_q == 32'h0000_0000 && !c1
            && (mode == MODE_FAST_OFF || mode == MODE_SLOW_OFF)) |=> (st_q == ST_OFF && !drive_enable);
    endproperty
    a_off: assert property (p_off) else $error("off mode did not disable");

    property p_brake;
        (st_q == ST_BRAKE) |-> (brake_current == $past(brake_q));
    endproperty
    a_brake: assert property (p_brake) else $error("brake current mismatch");

    property p_latch;
        (flt_q != '0 && !clr) |=> ((flt_q & $past(flt_q)) == $past(flt_q));
    endproperty
    a_latch: assert property (p_latch) else $error("fault bit lost without clear");

endmodule
`default_nettype wire

// ### test/sfs_partner.sv
`timescale 1ns/10ps
`default_nettype none
module sfs_partner
    import sfs_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        spike,
    input  wire logic [15:0] volt_set,
    output sfs_sample_t      measured_current_percent,
    output logic [15:0]      bus_voltage_reading,
    output logic             relay_closed_pin,
    output logic             encoder_present_pin
);
    int seed = 96486;
    int cnt;
    // Current held at zero until well after the relay closes, so the offset check sees none
    always @(posedge core_clk) begin
        cnt <= srst ? 0 : cnt + 1;
        relay_closed_pin <= cnt > 8;
        encoder_present_pin <= 1'b1;
        bus_voltage_reading <= volt_set;
        measured_current_percent.valid <= cnt[1:0] == 2'h0;
        // A spike sample makes a current jump without reaching the overcurrent threshold
        measured_current_percent.pct <= spike ? 16'h0050
                                        : (cnt > 20) ? 16'($unsigned($random(seed)) % 16) : 16'h0000;
    end
endmodule
`default_nettype wire

// ### test/tb_servo_fault_supervisor.sv
`timescale 1ns/10ps
`default_nettype none
module tb_servo_fault_supervisor;
    import sfs_pkg::*;
    logic core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, v380 = 0, sw_ot = 0, efv = 0, seen;
    logic pready, pslverr, err, drive_enable, decel_active, fault_pending, relay, enc;
    logic lni = 0, lno = 0, hwot = 0, spk = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [9:0] efc = 10'h000, fault_code;
    logic [15:0] volt = 16'h0136, spd = 16'h0064, brake_current, bus;
    sfs_sample_t cur;
    int errors = 0, check_count = 0, cyc = 0, regm[int];
    int vv[6] = '{420, 421, 421, 751, 218, 217}, vs[6] = '{0, 0, 1, 1, 0, 0}, vc[6] = '{0, 102, 0, 102, 0, 103};
    initial forever #12.5 core_clk = ~core_clk;
    sfs_partner pm (.core_clk(core_clk), .srst(srst), .spike(spk), .volt_set(volt), .measured_current_percent(cur),
        .bus_voltage_reading(bus), .relay_closed_pin(relay), .encoder_present_pin(enc));
    sfs_top #(.MS_CYC(4)) uut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .relay_closed_pin(relay), .encoder_present_pin(enc), .variant_380_pin(v380), .hw_overtravel_pin(hwot),
        .sw_overtravel(sw_ot), .measured_current_percent(cur), .bus_voltage_reading(bus), .nvm_check('0),
        .ipc_check('0), .phase_check('0), .learn_no_index(lni), .learn_no_offset(lno), .ext_fault_valid(efv),
        .ext_fault_code(efc), .motor_speed(spd), .rated_speed(spd), .drive_enable(drive_enable),
        .decel_active(decel_active), .brake_current(brake_current), .fault_code(fault_code),
        .fault_pending(fault_pending));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Model keeps stop selectors unchanged on values above five
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge core_clk) penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (w && a < 8'h28 && !(a < 8'h0c && d > 5)) regm[a] = d[15:0];
    endtask
    task automatic rdall;
        foreach (regm[a]) begin
            apb(1'b0, a[7:0], 0);
            chk(rd, regm[a]);
        end
    endtask
    task automatic clr;
        apb(1'b1, 8'h28, 1);
        repeat (4) @(posedge core_clk);
    endtask
    task automatic conclude;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            conclude;
        end
    end
    initial begin
        regm = '{0: 0, 4: 0, 8: 0, 12: 500, 16: 1000, 20: 0, 24: 300};
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        repeat (20) @(posedge core_clk);
        rdall;
        apb(1'b0, 8'h30, 0);
        chk(err, 1);
        apb(1'b1, 8'h04, 6);
        apb(1'b1, 8'h0c, 2);
        apb(1'b1, 8'h10, 3);
        apb(1'b1, 8'h14, 32'h123);
        rdall;
        $display("done: registers");
        for (int s = 0; s < 3; s++)
            for (int m = 0; m < 6; m++) begin
                apb(1'b1, s == 1 ? 8'h08 : (s ? 8'h00 : 8'h04), m);
                @(posedge core_clk) if (s == 1) sw_ot <= 1'b1; else {efv, efc} <= {1'b1, s ? 10'd300 : 10'd600};
                @(posedge core_clk) {sw_ot, efv} <= 2'b00;
                seen = 0;
                repeat (40) @(posedge core_clk) seen |= decel_active;
                chk(drive_enable, m >= 3);
                chk(seen, m inside {[1:4]});
                chk(brake_current, m == 5 ? 32'h123 : 0);
                chk(fault_code, s == 1 ? 207 : (s ? 300 : 600));
                clr;
            end
        $display("done: stop modes");
        apb(1'b1, 8'h1c, 2);
        apb(1'b1, 8'h18, 10);
        repeat (80) @(posedge core_clk);
        chk(fault_pending, 0);
        apb(1'b1, 8'h1c, 0);
        repeat (80) @(posedge core_clk);
        chk(fault_code, 100);
        chk(drive_enable, 0);
        apb(1'b1, 8'h18, 300);
        clr;
        $display("done: overcurrent");
        for (int i = 0; i < 6; i++) begin
            {v380, volt} <= {vs[i][0], vv[i][15:0]};
            repeat (10) @(posedge core_clk);
            clr;
            chk(fault_code, vc[i]);
        end
        volt <= 16'h0136;
        clr;
        $display("done: bus voltage");
        lno <= 1'b1;
        @(posedge core_clk) lno <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(fault_code, 114);
        lni <= 1'b1;
        @(posedge core_clk) lni <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(fault_code, 113);
        chk(drive_enable, 0);
        clr;
        spk <= 1'b1;
        repeat (4) @(posedge core_clk);
        spk <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk(fault_code, 109);
        clr;
        hwot <= 1'b1;
        repeat (6) @(posedge core_clk);
        hwot <= 1'b0;
        chk(fault_code, 208);
        chk(brake_current, 32'h123);
        repeat (3) @(posedge core_clk);
        clr;
        $display("done: learn, jump and limits");
        conclude;
    end
endmodule
`default_nettype wire
